// ---- long_decode_pkg.sv ----
// Package of decode constants for the long multiply/divide and coprocessor spaces
// Function
// - Major 000/minor 0000 is signed long multiply; major 010/minor 0000 unsigned.
// - Major 001 signed divide, 011 unsigned divide, only with minor 1111.
// - Major 100 with minor 0000 is signed long multiply-accumulate.
// - Major 100 minor 10xx half MAC, 110x dual MAC; DSP variant only.
// - Major 101 minor 110x is signed dual long multiply-subtract; DSP only.
// - Major 110 minor 0000 unsigned MAC; minor 0110 double-accumulate, DSP only.
// - Any unmatched encoding is an undefined instruction; in the coprocessor space only if the unit is present and enabled.
// - Coprocessor major 0xxxx0 store, 0xxxx1 load, excluding 000x0x.
// - Coprocessor major 000100 writes two core registers, op and number ignored.
// - Coprocessor major 000101 reads into two core registers.
// - Coprocessor major 10xxxx with op clear is a data operation.
// - Op set with major 10xxx0 is a single core register write.
// - Op set with major 10xxx1 is a single read into a core register.
// - Coprocessor instruction executes or faults undefined only if unit present and enabled.
// - Absent or disabled unit raises usage error and sets absent-unit flag.
// - Floating-point extension adds instructions but leaves operating states unchanged.
// - Fields shown as dash do not affect instruction selection.
package long_decode_pkg;

  localparam logic [8:0] LONG_SPACE_PATTERN = 9'h1f7;
  localparam int         LONG_SPACE_HI      = 15;
  localparam int         LONG_SPACE_LO      = 7;
  localparam int         LONG_MAJOR_HI      = 6;
  localparam int         LONG_MAJOR_LO      = 4;
  localparam int         LONG_MINOR_HI      = 7;
  localparam int         LONG_MINOR_LO      = 4;

  // Coprocessor space prefix: first-half bits 15:13 = 111, bits 11:10 = 11
  localparam logic [2:0] CP_PREFIX_HI       = 3'h7;
  localparam logic [1:0] CP_PREFIX_LO       = 2'h3;
  localparam int         CP_MAJOR_HI        = 9;
  localparam int         CP_MAJOR_LO        = 4;
  localparam int         CP_NUM_HI          = 11;
  localparam int         CP_NUM_LO          = 8;
  localparam int         CP_OP_BIT          = 4;

  localparam logic [2:0] MAJ_SMUL           = 3'h0;
  localparam logic [2:0] MAJ_SIGNED_DIVIDE           = 3'h1;
  localparam logic [2:0] MAJ_UMUL           = 3'h2;
  localparam logic [2:0] MAJ_UNSIGNED_DIVIDE           = 3'h3;
  localparam logic [2:0] MAJ_SMAC           = 3'h4;
  localparam logic [2:0] MAJ_SMSUB          = 3'h5;
  localparam logic [2:0] MAJ_UMAC           = 3'h6;
  localparam logic [3:0] MIN_PLAIN          = 4'h0;
  localparam logic [3:0] MIN_DIV            = 4'hf;
  localparam logic [3:0] MIN_UDACC          = 4'h6;
  localparam logic [1:0] MIN_HALF_TOP       = 2'h2;
  localparam logic [2:0] MIN_DUAL_TOP       = 3'h6;

  localparam logic [5:0] CP_MAJ_PAIR_WR     = 6'h04;
  localparam logic [5:0] CP_MAJ_PAIR_RD     = 6'h05;

  // One-hot operation codes reported to the execution side
  typedef enum logic [13:0] {
    OP_NONE                    = 14'h0001,
    OP_SIGNED_MUL_LONG         = 14'h0002,
    OP_UNSIGNED_MUL_LONG       = 14'h0004,
    OP_SIGNED_DIVIDE           = 14'h0008,
    OP_UNSIGNED_DIVIDE         = 14'h0010,
    OP_SIGNED_MAC_LONG         = 14'h0020,
    OP_SIGNED_HALF_MAC_LONG    = 14'h0040,
    OP_SIGNED_DUAL_MAC_LONG    = 14'h0080,
    OP_SIGNED_DUAL_MSUB_LONG   = 14'h0100,
    OP_UNSIGNED_MAC_LONG       = 14'h0200,
    OP_UNSIGNED_DOUBLE_ACC_MUL = 14'h0400,
    OP_UNIT_INSTR              = 14'h0800,
    OP_UNDEFINED               = 14'h1000,
    OP_ABSENT_UNIT             = 14'h2000
  } decode_op_e;

  // One-hot coprocessor instruction classes
  typedef enum logic [7:0] {
    UNIT_NONE                  = 8'h01,
    UNIT_STORE_TO_UNIT         = 8'h02,
    UNIT_LOAD_TO_UNIT          = 8'h04,
    UNIT_PAIR_WRITE_TO_UNIT    = 8'h08,
    UNIT_PAIR_READ_FROM_UNIT   = 8'h10,
    UNIT_DATA_OPERATION        = 8'h20,
    UNIT_SINGLE_WRITE_TO_UNIT  = 8'h40,
    UNIT_SINGLE_READ_FROM_UNIT = 8'h80
  } unit_class_e;

endpackage : long_decode_pkg

// ---- unit_class_decode.sv ----
// Combinational classifier for the coprocessor encoding space
`timescale 1ns/100ps
module unit_class_decode (
  input  wire logic [5:0]                  i_major_opcode_field,
  input  wire logic                        i_op_bit,
  output long_decode_pkg::unit_class_e     o_unit_class
);
  import long_decode_pkg::*;

  // load store split, 000x0x carved out for the pair moves
  wire is_excluded = (i_major_opcode_field[5:3] == 3'h0) && !i_major_opcode_field[1];
  wire is_ldst     = !i_major_opcode_field[5] && !is_excluded;
  // pair write, op and number ignored
  wire is_pair_wr  = (i_major_opcode_field == CP_MAJ_PAIR_WR);
  wire is_pair_rd  = (i_major_opcode_field == CP_MAJ_PAIR_RD);
  wire is_reg_grp  = (i_major_opcode_field[5:4] == 2'h2);

  // data operation or single moves; rest is none
  assign o_unit_class =
    is_ldst ? (i_major_opcode_field[0] ? UNIT_LOAD_TO_UNIT : UNIT_STORE_TO_UNIT) :
    is_pair_wr ? UNIT_PAIR_WRITE_TO_UNIT :
    is_pair_rd ? UNIT_PAIR_READ_FROM_UNIT :
    (is_reg_grp && !i_op_bit) ? UNIT_DATA_OPERATION :
    (is_reg_grp && !i_major_opcode_field[0]) ? UNIT_SINGLE_WRITE_TO_UNIT :
    is_reg_grp ? UNIT_SINGLE_READ_FROM_UNIT :
    UNIT_NONE;

endmodule : unit_class_decode

// ---- long_mul_div_coproc_decode.sv ----
// Registered decoder for long multiply/divide and coprocessor instruction spaces
`timescale 1ns/100ps
module long_mul_div_coproc_decode (
  input  wire logic                        i_clk,
  input  wire logic                        i_reset_n,
  input  wire logic                        i_instr_valid,
  input  wire logic [15:0]                 i_first_half,
  input  wire logic [15:0]                 i_second_half,
  input  wire logic                        i_dsp_variant,
  input  wire logic                        i_privileged,
  input  wire logic [15:0]                 i_unit_present,
  input  wire logic [15:0]                 i_unit_priv_enable,
  input  wire logic [15:0]                 i_unit_user_enable,
  output logic                             o_decode_valid,
  output long_decode_pkg::decode_op_e      o_decode_op,
  output long_decode_pkg::unit_class_e     o_unit_class,
  output logic [3:0]                       o_unit_number,
  output logic [1:0]                       o_operand_select,
  output logic                             o_usage_error_exception,
  output logic                             o_absent_unit_flag
);
  import long_decode_pkg::*;

  // field extraction for the long space
  wire       in_long_space = (i_first_half[LONG_SPACE_HI:LONG_SPACE_LO] == LONG_SPACE_PATTERN);
  wire [2:0] major_long    = i_first_half[LONG_MAJOR_HI:LONG_MAJOR_LO];
  wire [3:0] minor_long    = i_second_half[LONG_MINOR_HI:LONG_MINOR_LO];

  // field extraction for the coprocessor space
  wire       in_unit_space = (i_first_half[15:13] == CP_PREFIX_HI) &&
                             (i_first_half[11:10] == CP_PREFIX_LO);
  wire [5:0] major_unit    = i_first_half[CP_MAJOR_HI:CP_MAJOR_LO];
  wire [3:0] unit_number   = i_second_half[CP_NUM_HI:CP_NUM_LO];
  wire       unit_op_bit   = i_second_half[CP_OP_BIT];

  // Minor opcode pattern matches; don't-care bits are simply not compared
  wire minor_plain = (minor_long == MIN_PLAIN);
  wire minor_div   = (minor_long == MIN_DIV);
  wire minor_half  = (minor_long[3:2] == MIN_HALF_TOP);
  wire minor_dual  = (minor_long[3:1] == MIN_DUAL_TOP);
  wire minor_udacc = (minor_long == MIN_UDACC);

  wire sel_signed_mul_long = (major_long == MAJ_SMUL) && minor_plain;
  wire sel_unsigned_mul_long = (major_long == MAJ_UMUL) && minor_plain;
  wire sel_signed_divide  = (major_long == MAJ_SIGNED_DIVIDE) && minor_div;
  wire sel_unsigned_divide  = (major_long == MAJ_UNSIGNED_DIVIDE) && minor_div;
  wire sel_signed_mac_long = (major_long == MAJ_SMAC) && minor_plain;
  // DSP-only half and dual accumulate forms
  wire sel_shalf = (major_long == MAJ_SMAC) && minor_half && i_dsp_variant;
  wire sel_sdual = (major_long == MAJ_SMAC) && minor_dual && i_dsp_variant;
  wire sel_sdsub = (major_long == MAJ_SMSUB) && minor_dual && i_dsp_variant;
  wire sel_unsigned_mac_long = (major_long == MAJ_UMAC) && minor_plain;
  wire sel_unsigned_double_acc_mul = (major_long == MAJ_UMAC) && minor_udacc && i_dsp_variant;

  // Priority-free selection: the long patterns are mutually exclusive
  wire decode_op_e long_op =
    sel_signed_mul_long ? OP_SIGNED_MUL_LONG :
    sel_unsigned_mul_long ? OP_UNSIGNED_MUL_LONG :
    sel_signed_divide  ? OP_SIGNED_DIVIDE :
    sel_unsigned_divide  ? OP_UNSIGNED_DIVIDE :
    sel_signed_mac_long ? OP_SIGNED_MAC_LONG :
    sel_shalf ? OP_SIGNED_HALF_MAC_LONG :
    sel_sdual ? OP_SIGNED_DUAL_MAC_LONG :
    sel_sdsub ? OP_SIGNED_DUAL_MSUB_LONG :
    sel_unsigned_mac_long ? OP_UNSIGNED_MAC_LONG :
    sel_unsigned_double_acc_mul ? OP_UNSIGNED_DOUBLE_ACC_MUL :
    OP_UNDEFINED;

  // Halves select for half MAC, exchange bit for the dual forms
  // A coprocessor word can carry the same bits here, so only the long space may steer them
  wire [1:0] long_operand_sel = !in_long_space ? 2'h0 :
                                sel_shalf ? minor_long[1:0] :
                                (sel_sdual || sel_sdsub) ? {1'b0, minor_long[0]} : 2'h0;

  // Coprocessor class from the shared classifier
  unit_class_e unit_class;
  unit_class_decode u_unit_class (
    .i_major_opcode_field (major_unit),
    .i_op_bit             (unit_op_bit),
    .o_unit_class         (unit_class)
  );

  // unit must exist and be enabled at the current privilege
  wire unit_enabled   = i_privileged ? i_unit_priv_enable[unit_number]
                                     : i_unit_user_enable[unit_number];
  wire unit_usable    = i_unit_present[unit_number] && unit_enabled;
  wire unit_known     = (unit_class != UNIT_NONE);

  // Access check precedes class decode: an unreachable unit never reports undefined
  // absent or disabled unit gives the absent-unit fault
  // unmatched coprocessor encodings fall to undefined
  wire decode_op_e unit_op = !unit_usable ? OP_ABSENT_UNIT :
                             unit_known   ? OP_UNIT_INSTR  : OP_UNDEFINED;

  // Space selection; neither space claimed reports nothing
  // no state machine here changes with the floating-point extension
  wire decode_op_e op_next = in_long_space ? long_op :
                             in_unit_space ? unit_op : OP_NONE;
  wire unit_class_e class_next = (in_unit_space && !in_long_space && unit_usable)
                                 ? unit_class : UNIT_NONE;
  wire       valid_next  = i_instr_valid && (in_long_space || in_unit_space);
  wire       fault_next  = valid_next && ((op_next == OP_UNDEFINED) ||
                                          (op_next == OP_ABSENT_UNIT));
  wire       absent_next = valid_next && (op_next == OP_ABSENT_UNIT);

  // Output registers: one-cycle decode latency, each result lasts one cycle
  decode_op_e  decode_op_reg;
  unit_class_e unit_class_reg;
  logic        decode_valid_reg;
  logic [3:0]  unit_number_reg;
  logic [1:0]  operand_select_reg;
  logic        usage_error_reg;
  logic        absent_unit_reg;

  // Valid pulse: one cycle per claimed instruction
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      decode_valid_reg <= 1'b0;
    end else begin
      decode_valid_reg <= valid_next;
    end
  end

  // Operation code; idle cycles show no operation rather than a stale one
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      decode_op_reg <= OP_NONE;
    end else begin
      decode_op_reg <= valid_next ? op_next : OP_NONE;
    end
  end

  // Coprocessor class, only for a reachable unit
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      unit_class_reg <= UNIT_NONE;
    end else begin
      unit_class_reg <= valid_next ? class_next : UNIT_NONE;
    end
  end

  // Unit number follows the second half every cycle; users qualify it with the class
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      unit_number_reg <= 4'h0;
    end else begin
      unit_number_reg <= unit_number;
    end
  end

  // Operand steering, held at zero when nothing is claimed
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      operand_select_reg <= 2'h0;
    end else begin
      operand_select_reg <= valid_next ? long_operand_sel : 2'h0;
    end
  end

  // Fault pulses; no sticky status is kept in this block
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      usage_error_reg <= 1'b0;
      absent_unit_reg <= 1'b0;
    end else begin
      usage_error_reg <= fault_next;
      absent_unit_reg <= absent_next;
    end
  end

  assign o_decode_valid          = decode_valid_reg;
  assign o_decode_op             = decode_op_reg;
  assign o_unit_class            = unit_class_reg;
  assign o_unit_number           = unit_number_reg;
  assign o_operand_select        = operand_select_reg;
  assign o_usage_error_exception = usage_error_reg;
  assign o_absent_unit_flag      = absent_unit_reg;

endmodule : long_mul_div_coproc_decode

// ---- unit_bank_model.sv ----
// Model of the attached coprocessor units: which exist and who may reach them
`timescale 1ns/100ps
module unit_bank_model (
  input  wire logic        i_all_off,
  output logic [15:0]      o_present,
  output logic [15:0]      o_priv_enable,
  output logic [15:0]      o_user_enable
);
  // Units 0..7 fitted; user level reaches 0..3 only, so 4..7 trap when unprivileged
  assign o_present     = i_all_off ? 16'h0000 : 16'h00ff;
  assign o_priv_enable = i_all_off ? 16'h0000 : 16'h00ff;
  assign o_user_enable = i_all_off ? 16'h0000 : 16'h000f;
endmodule : unit_bank_model

// ---- long_mul_div_coproc_decode_checker.sv ----
// Port-level checks of the registered long and coprocessor decoder
`timescale 1ns/100ps
module long_decode_checker
  import long_decode_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_instr_valid,
  input wire logic        i_dsp_variant,
  input wire logic        i_privileged,
  input wire logic [15:0] i_first_half,
  input wire logic [15:0] i_second_half,
  input wire logic [15:0] i_unit_present,
  input wire logic [15:0] i_unit_priv_enable,
  input wire logic [15:0] i_unit_user_enable,
  input wire logic        o_decode_valid,
  input wire logic        o_usage_error_exception,
  input wire logic        o_absent_unit_flag,
  input wire decode_op_e  o_decode_op,
  input wire unit_class_e o_unit_class,
  input wire logic [3:0]  o_unit_number,
  input wire logic [1:0]  o_operand_select
);
  // Space recognition and field extraction, worked out independently of the design
  wire logic [3:0] num = i_second_half[11:8];
  wire logic [2:0] maj = i_first_half[6:4];
  wire logic [3:0] mnr = i_second_half[7:4];
  wire logic [5:0] cmaj = i_first_half[9:4];
  wire logic lsp = i_instr_valid && i_first_half[15:7] == 9'h1f7;
  wire logic csp = i_instr_valid && i_first_half[15:13] == 3'h7 && i_first_half[11:10] == 2'h3;
  wire logic ok = i_unit_present[num]
                  && (i_privileged ? i_unit_priv_enable[num] : i_unit_user_enable[num]);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  AST_SIGNED_MUL: assert property (lsp && maj == 3'h0 && mnr == 4'h0 |=>
    o_decode_op == OP_SIGNED_MUL_LONG) else $error("signed long multiply not selected");
  AST_DIV_MINOR: assert property (lsp && maj == 3'h1 && mnr != 4'hf |=>
    o_decode_op == OP_UNDEFINED && o_usage_error_exception) else $error("bad divide taken");
  AST_HALF_MAC: assert property (lsp && maj == 3'h4 && mnr[3:2] == 2'h2 && i_dsp_variant |=>
    o_decode_op == OP_SIGNED_HALF_MAC_LONG && o_operand_select == $past(i_second_half[5:4]))
    else $error("half multiply-accumulate wrong");
  AST_DOUBLE_ACC: assert property (lsp && maj == 3'h6 && mnr == 4'h6 && i_dsp_variant |=>
    o_decode_op == OP_UNSIGNED_DOUBLE_ACC_MUL) else $error("double accumulate not selected");
  AST_PAIR_WRITE: assert property (csp && ok && cmaj == 6'h04 |=>
    o_unit_class == UNIT_PAIR_WRITE_TO_UNIT && o_decode_op == OP_UNIT_INSTR)
    else $error("pair write not selected");
  AST_DATA_OP: assert property (csp && ok && cmaj[5:4] == 2'h2 && !i_second_half[4] |=>
    o_unit_class == UNIT_DATA_OPERATION) else $error("data operation not selected");
  AST_ABSENT: assert property (csp && !ok |=>
    o_absent_unit_flag && o_usage_error_exception && o_decode_op == OP_ABSENT_UNIT)
    else $error("absent unit not faulted");
  AST_IDLE: assert property (!i_instr_valid |=>
    o_decode_op == OP_NONE && !o_decode_valid && !o_usage_error_exception)
    else $error("output without a request");
  AST_UNIT_NO_SELECT: assert property (csp |=> o_operand_select == 2'h0)
    else $error("coprocessor word steered operand halves");
  COV_ABSENT: cover property (o_absent_unit_flag);
  COV_STORE: cover property (o_unit_class == UNIT_STORE_TO_UNIT);
  COV_DIVIDE: cover property (o_decode_op == OP_SIGNED_DIVIDE);
endmodule : long_decode_checker

bind long_mul_div_coproc_decode long_decode_checker checker_inst (.*);

// ---- test_long_mul_div_coproc_decode.sv ----
// Self-checking bench for the long multiply/divide and coprocessor decoder
`timescale 1ns/100ps
module test_long_mul_div_coproc_decode;
  import long_decode_pkg::*;
  typedef struct {
    logic [15:0] f;
    logic [15:0] s;
    logic [1:0]  m;
    decode_op_e  op;
    unit_class_e cls;
    logic [1:0]  sel;
  } row_s;
  logic        i_clk, i_reset_n, i_instr_valid, i_dsp_variant, i_privileged, all_off;
  logic [15:0] i_first_half, i_second_half, i_unit_present, i_unit_priv_enable;
  logic [15:0] i_unit_user_enable;
  logic        o_decode_valid, o_usage_error_exception, o_absent_unit_flag;
  decode_op_e  o_decode_op;
  unit_class_e o_unit_class;
  logic [3:0]  o_unit_number;
  logic [1:0]  o_operand_select;
  int          err_count;
  int          checks_done;
  // Field m is {dsp variant, privileged}; rows run back to back, one per cycle
  row_s rows [$] = '{
    '{16'hfb80, 16'h0000, 2'h3, OP_SIGNED_MUL_LONG, UNIT_NONE, 2'h0},
    '{16'hfba0, 16'h0000, 2'h3, OP_UNSIGNED_MUL_LONG, UNIT_NONE, 2'h0},
    '{16'hfb8f, 16'hff0f, 2'h3, OP_SIGNED_MUL_LONG, UNIT_NONE, 2'h0},
    '{16'hfb90, 16'h00f0, 2'h3, OP_SIGNED_DIVIDE, UNIT_NONE, 2'h0},
    '{16'hfbb0, 16'h00f0, 2'h3, OP_UNSIGNED_DIVIDE, UNIT_NONE, 2'h0},
    '{16'hfb90, 16'h00e0, 2'h3, OP_UNDEFINED, UNIT_NONE, 2'h0},
    '{16'hfbc0, 16'h0000, 2'h3, OP_SIGNED_MAC_LONG, UNIT_NONE, 2'h0},
    '{16'hfbc0, 16'h00b0, 2'h3, OP_SIGNED_HALF_MAC_LONG, UNIT_NONE, 2'h3},
    '{16'hfbc0, 16'h00d0, 2'h3, OP_SIGNED_DUAL_MAC_LONG, UNIT_NONE, 2'h1},
    '{16'hfbc0, 16'h00b0, 2'h1, OP_UNDEFINED, UNIT_NONE, 2'h0},
    '{16'hfbd0, 16'h00c0, 2'h3, OP_SIGNED_DUAL_MSUB_LONG, UNIT_NONE, 2'h0},
    '{16'hfbe0, 16'h0060, 2'h3, OP_UNSIGNED_DOUBLE_ACC_MUL, UNIT_NONE, 2'h0},
    '{16'hfbf0, 16'h0000, 2'h3, OP_UNDEFINED, UNIT_NONE, 2'h0},
    '{16'h0000, 16'h0000, 2'h3, OP_NONE, UNIT_NONE, 2'h0},
    '{16'hec30, 16'h0100, 2'h3, OP_UNIT_INSTR, UNIT_LOAD_TO_UNIT, 2'h0},
    '{16'hec10, 16'h0100, 2'h3, OP_UNDEFINED, UNIT_NONE, 2'h0},
    '{16'hec40, 16'h0510, 2'h3, OP_UNIT_INSTR, UNIT_PAIR_WRITE_TO_UNIT, 2'h0},
    '{16'hec40, 16'h05b0, 2'h3, OP_UNIT_INSTR, UNIT_PAIR_WRITE_TO_UNIT, 2'h0},
    '{16'hec50, 16'h0500, 2'h3, OP_UNIT_INSTR, UNIT_PAIR_READ_FROM_UNIT, 2'h0},
    '{16'hee30, 16'h0200, 2'h3, OP_UNIT_INSTR, UNIT_DATA_OPERATION, 2'h0},
    '{16'hee20, 16'h0210, 2'h3, OP_UNIT_INSTR, UNIT_SINGLE_WRITE_TO_UNIT, 2'h0},
    '{16'hee10, 16'h0210, 2'h3, OP_UNIT_INSTR, UNIT_SINGLE_READ_FROM_UNIT, 2'h0},
    '{16'hec20, 16'h0900, 2'h3, OP_ABSENT_UNIT, UNIT_NONE, 2'h0},
    '{16'hec20, 16'h0500, 2'h2, OP_ABSENT_UNIT, UNIT_NONE, 2'h0},
    '{16'hec20, 16'h0200, 2'h2, OP_UNIT_INSTR, UNIT_STORE_TO_UNIT, 2'h0},
    '{16'hec20, 16'h0100, 2'h3, OP_UNIT_INSTR, UNIT_STORE_TO_UNIT, 2'h0}};

  long_mul_div_coproc_decode DUT (.i_clk, .i_reset_n, .i_instr_valid, .i_first_half,
    .i_second_half, .i_dsp_variant, .i_privileged, .i_unit_present, .i_unit_priv_enable,
    .i_unit_user_enable, .o_decode_valid, .o_decode_op, .o_unit_class, .o_unit_number,
    .o_operand_select, .o_usage_error_exception, .o_absent_unit_flag);
  unit_bank_model units (.i_all_off(all_off), .o_present(i_unit_present),
    .o_priv_enable(i_unit_priv_enable), .o_user_enable(i_unit_user_enable));

  // Free-running 50 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic drive(input row_s r);
    i_first_half = r.f;
    i_second_half = r.s;
    {i_dsp_variant, i_privileged} = r.m;
  endtask : drive

  // Outputs stand one cycle, so the caller samples just after the answering edge
  task automatic check_row(input row_s r);
    checks_done++;
    if (o_decode_op !== r.op || o_unit_class !== r.cls || o_operand_select !== r.sel
        || o_decode_valid !== (r.op != OP_NONE) || o_unit_number !== r.s[11:8]
        || o_usage_error_exception !== (r.op inside {OP_UNDEFINED, OP_ABSENT_UNIT})
        || o_absent_unit_flag !== (r.op == OP_ABSENT_UNIT)) begin
      err_count++;
      $display("mismatch at %0t: %h %h gave op %h class %h", $time, r.f, r.s,
               o_decode_op, o_unit_class);
    end
  endtask : check_row

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    row_s probe;
    err_count = 0;
    checks_done = 0;
    all_off = 1'b0;
    i_reset_n = 1'b0;
    i_instr_valid = 1'b0;
    drive(rows[0]);
    repeat (5) @(posedge i_clk);
    #2 i_reset_n = 1'b1;
    // Each row is driven while the answer to the row before it is checked
    foreach (rows[k]) begin
      @(posedge i_clk);
      #2;
      if (k > 0) check_row(rows[k-1]);
      drive(rows[k]);
      i_instr_valid = 1'b1;
    end
    @(posedge i_clk);
    #2;
    check_row(rows[rows.size()-1]);
    probe = rows[rows.size()-1];
    probe.op = OP_ABSENT_UNIT;
    probe.cls = UNIT_NONE;
    // Same store with every unit switched off by the far side must trap
    all_off = 1'b1;
    @(posedge i_clk);
    #2;
    check_row(probe);
    i_instr_valid = 1'b0;
    probe.op = OP_NONE;
    @(posedge i_clk);
    #2;
    check_row(probe);
    // Reset in mid-run with a trapping store in flight clears outputs at once
    i_instr_valid = 1'b1;
    @(posedge i_clk);
    #2 i_reset_n = 1'b0;
    #2;
    check_row('{16'h0000, 16'h0000, 2'h3, OP_NONE, UNIT_NONE, 2'h0});
    // Release again with an instruction waiting: it decodes at the first edge after
    all_off = 1'b0;
    drive(rows[0]);
    @(posedge i_clk);
    #2 i_reset_n = 1'b1;
    @(posedge i_clk);
    #2;
    check_row(rows[0]);
    give_verdict();
  end
endmodule : test_long_mul_div_coproc_decode
